// file: hw/acfs_defs.vh
/*
 * register map, field positions, reset values and codes of the
 * converter compare / fifo sequencer.
 * assumes a 32-bit ahb-lite slave, one aligned word per register.
 */
`ifndef ACFS_DEFS_VH
`define ACFS_DEFS_VH

// byte offsets
`define ACFS_SC1_OFF  8'h00
`define ACFS_SC2_OFF  8'h04
`define ACFS_SC3_OFF  8'h08
`define ACFS_SC4_OFF  8'h0C
`define ACFS_RH_OFF   8'h10
`define ACFS_RL_OFF   8'h14
`define ACFS_CVH_OFF  8'h18
`define ACFS_CVL_OFF  8'h1C

// control_status_one fields
`define ACFS_SC1_CONT 5
`define ACFS_SC1_COMPLETE_INTERRUPT_ENABLE 6
`define ACFS_SC1_CONVERSION_COMPLETE_FLAG 7
// control_status_two fields
`define ACFS_SC2_HWT  0
`define ACFS_SC2_CMPE 1
`define ACFS_SC2_DIR  2
`define ACFS_SC2_BUSY 7
// control_status_four fields
`define ACFS_SC4_CMB  5
`define ACFS_SC4_SCAN 6

// reset values and codes
`define ACFS_CHAN_OFF   5'h1F
`define ACFS_CLK_ASYNC  2'h3
`define ACFS_ZERO_WORD  32'h00000000
`define ACFS_FIFO_MAX   4'h8

`endif

// file: hw/acfs_top.v
/*
 * digital control of a successive-approximation converter: compare
 * against a software limit, channel and result fifo sequencer with
 * scan and continuous modes, stop mode handling, ahb-lite registers.
 * assumes an analog core that takes a start pulse with a channel and
 * returns a one-cycle done pulse with a 10-bit result, all on hclk.
 */
// Chosen here: the AHB-Lite register port and the register addresses.
// Functional notes
// - compare subtracts limit, difference is stored
// - upper limit: flag when result >= limit
// - lower limit: flag when result < limit
// - single channel false compare: no flag, no result update
// - interrupt request follows flag and enable
// - fifo compare flag by any or all
// - fifo stores every difference regardless
// - nonzero depth field enables fifo mode
// - plain fifo conversion waits for full channels, scan starts on first write
// - fifo read of channel shows active one
// - channel write refills and aborts sequence
// - fifo flag only after whole sequence
// - software trigger fetches next channel immediately
// - hardware trigger needed for next channel
// - single mode halts until refill or trigger
// - scan repeats first channel, flag at depth
// - continuous fifo restarts from first entry
// - wait mode leaves conversions running
// - stop without async clock aborts to idle
// - async clock runs in stop, not fifo
// - mode register writes abort conversions
`timescale 1ns/10ps
`include "acfs_defs.vh"

module acfs_top (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	input  wire        hw_trigger,
	input  wire        stop_mode,
	input  wire        core_done,
	input  wire [9:0]  core_result,
	output reg         core_start,
	output reg         core_abort,
	output reg  [4:0]  core_channel,
	output reg         irq
);

	// sequencer states, one-hot
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_ARM  = 3'h2;
	localparam [2:0] ST_CONV = 3'h4;

	// software visible control
	reg  [4:0]  channel_select_field;  // last channel written
	reg         continuous_enable_bit;
	reg         complete_interrupt_enable;
	reg         conversion_complete_flag;
	reg         hw_trig_sel;           // 1: hardware trigger
	reg         cmp_en;                // compare function on
	reg         compare_direction_bit; // 1: upper limit
	reg  [1:0]  clk_sel;               // conversion clock source
	reg  [2:0]  fifo_depth_field;
	reg         compare_combine_bit;   // 1: all must hold
	reg         scan_mode_enable;
	reg  [7:0]  compare_value_high;
	reg  [7:0]  compare_value_low;
	reg  [9:0]  res_reg;               // non-fifo result

	// fifo storage and sequencer state
	reg  [4:0]  chan_fifo [0:7];
	reg  [9:0]  res_fifo  [0:7];
	reg  [3:0]  cfill;                 // channel entries written
	reg  [3:0]  cidx;                  // entry being converted
	reg  [3:0]  rcnt;                  // results stored
	reg  [2:0]  rptr;                  // software read pointer
	reg         any_t;
	reg         all_t;
	reg  [2:0]  state;

	// bus data phase capture
	reg         dph_wr;
	reg  [7:0]  dph_addr;

	// address phase acceptance, whole words only
	wire        a_go = hsel & htrans[1] & hready & (hsize == 3'h2);
	wire        rd_lo = a_go & ~hwrite & (haddr[7:0] == `ACFS_RL_OFF);
	wire        w_sc1 = dph_wr & (dph_addr == `ACFS_SC1_OFF);
	wire        w_sc2 = dph_wr & (dph_addr == `ACFS_SC2_OFF);
	wire        w_sc3 = dph_wr & (dph_addr == `ACFS_SC3_OFF);
	wire        w_sc4 = dph_wr & (dph_addr == `ACFS_SC4_OFF);
	wire        w_cvh = dph_wr & (dph_addr == `ACFS_CVH_OFF);
	wire        w_cvl = dph_wr & (dph_addr == `ACFS_CVL_OFF);

	// fifo mode and depth, field value n means n+1 levels
	wire        fifo_on = (fifo_depth_field != 3'h0);
	wire [3:0]  depth = {1'b0, fifo_depth_field} + 4'h1;

	// channel fifo write position; a full fifo restarts the fill
	wire        cf_full = (cfill >= depth);
	wire        cf_we = w_sc1 & fifo_on;
	wire [2:0]  cf_wa = (scan_mode_enable | cf_full) ? 3'h0 : cfill[2:0];
	wire [3:0]  cf_next = (scan_mode_enable | cf_full) ? 4'h1
		: cfill + 4'h1;
	// scan starts on the first write, plain fifo only when full
	wire        cf_ready_next = scan_mode_enable | (cf_next == depth);
	wire        fifo_ready = scan_mode_enable ? (cfill != 4'h0)
		: (cfill == depth);

	// channel chosen for a given fifo index
	wire [3:0]  cidx_nx = cidx + 4'h1;
	wire [4:0]  chan_first = chan_fifo[0];
	wire [4:0]  chan_nx = scan_mode_enable ? chan_fifo[0]
		: chan_fifo[cidx_nx[2:0]];
	wire [4:0]  chan_now = !fifo_on ? channel_select_field
		: scan_mode_enable ? chan_fifo[0] : chan_fifo[cidx[2:0]];

	// compare arithmetic: result plus two's complement of limit
	wire [9:0]  cv = {compare_value_high[1:0], compare_value_low};
	wire [9:0]  diff = core_result + (~cv + 10'h001);
	wire        cond = compare_direction_bit ?
		(core_result >= cv) :
		(core_result < cv);
	wire [9:0]  store_val = cmp_en ? diff : core_result;
	wire        any_n = any_t | cond;
	wire        all_n = all_t & cond;
	wire        last = (rcnt + 4'h1) >= depth;

	// mode changes, and stop off the async clock or in fifo mode, abort everything in flight
	wire        stop_abort = stop_mode & (state != ST_IDLE) &
		((clk_sel != `ACFS_CLK_ASYNC) | fifo_on);
	wire        mode_wr = w_sc2 | w_sc3 | w_sc4 | w_cvh | w_cvl;
	wire        done_ev = (state == ST_CONV) & core_done;

	// result fifo write happens on every done in fifo mode
	wire        rf_we = done_ev & fifo_on;

	// per-entry storage for both fifos
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_ent
			// one channel and one result slot
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					chan_fifo[gi] <= 5'h00;
					res_fifo[gi] <= 10'h000;
				end else begin
					if (cf_we && (cf_wa == gi)) begin
						chan_fifo[gi] <= hwdata[4:0];
					end
					if (rf_we && (rcnt[2:0] == gi)) begin
						res_fifo[gi] <= store_val;
					end
				end
			end
		end
	endgenerate

	// ahb-lite slave: zero wait states, always okay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			dph_wr <= 1'b0;
			dph_addr <= 8'h00;
			hrdata <= `ACFS_ZERO_WORD;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			dph_wr <= a_go & hwrite;
			dph_addr <= haddr[7:0];
			// read data is registered at the address edge so it stands
			// through the whole data phase
			if (a_go && !hwrite) begin
				case (haddr[7:0])
				`ACFS_SC1_OFF: begin
					hrdata <= {24'h000000, conversion_complete_flag,
						complete_interrupt_enable, continuous_enable_bit,
						fifo_on ? core_channel : channel_select_field};
				end
				`ACFS_SC2_OFF: begin
					hrdata <= {24'h000000, state != ST_IDLE, 4'h0,
						compare_direction_bit, cmp_en, hw_trig_sel};
				end
				`ACFS_SC3_OFF: hrdata <= {30'h00000000, clk_sel};
				`ACFS_SC4_OFF: begin
					hrdata <= {25'h0000000, scan_mode_enable,
						compare_combine_bit, 2'h0, fifo_depth_field};
				end
				`ACFS_RH_OFF: begin
					hrdata <= {30'h00000000, fifo_on ?
						res_fifo[rptr][9:8] : res_reg[9:8]};
				end
				`ACFS_RL_OFF: begin
					hrdata <= {24'h000000, fifo_on ?
						res_fifo[rptr][7:0] : res_reg[7:0]};
				end
				`ACFS_CVH_OFF: hrdata <= {24'h000000, compare_value_high};
				`ACFS_CVL_OFF: hrdata <= {24'h000000, compare_value_low};
				default: hrdata <= `ACFS_ZERO_WORD;
				endcase
			end else begin
				hrdata <= `ACFS_ZERO_WORD;
			end
		end
	end

	// register writes land at the end of the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_select_field <= `ACFS_CHAN_OFF;
			continuous_enable_bit <= 1'b0;
			complete_interrupt_enable <= 1'b0;
			hw_trig_sel <= 1'b0;
			cmp_en <= 1'b0;
			compare_direction_bit <= 1'b0;
			clk_sel <= 2'h0;
			fifo_depth_field <= 3'h0;
			compare_combine_bit <= 1'b0;
			scan_mode_enable <= 1'b0;
			compare_value_high <= 8'h00;
			compare_value_low <= 8'h00;
		end else begin
			if (w_sc1) begin
				channel_select_field <= hwdata[4:0];
				continuous_enable_bit <= hwdata[`ACFS_SC1_CONT];
				complete_interrupt_enable <= hwdata[`ACFS_SC1_COMPLETE_INTERRUPT_ENABLE];
			end
			if (w_sc2) begin
				hw_trig_sel <= hwdata[`ACFS_SC2_HWT];
				cmp_en <= hwdata[`ACFS_SC2_CMPE];
				compare_direction_bit <= hwdata[`ACFS_SC2_DIR];
			end
			if (w_sc3) begin
				clk_sel <= hwdata[1:0];
			end
			if (w_sc4) begin
				fifo_depth_field <= hwdata[2:0];
				compare_combine_bit <= hwdata[`ACFS_SC4_CMB];
				scan_mode_enable <= hwdata[`ACFS_SC4_SCAN];
			end
			if (w_cvh) begin
				compare_value_high <= hwdata[7:0];
			end
			if (w_cvl) begin
				compare_value_low <= hwdata[7:0];
			end
		end
	end

	// sequencer: starts, fifo walk, compare outcome and completion flag
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			core_start <= 1'b0;
			core_abort <= 1'b0;
			core_channel <= 5'h00;
			conversion_complete_flag <= 1'b0;
			res_reg <= 10'h000;
			cfill <= 4'h0;
			cidx <= 4'h0;
			rcnt <= 4'h0;
			rptr <= 3'h0;
			any_t <= 1'b0;
			all_t <= 1'b1;
			irq <= 1'b0;
		end else begin
			core_start <= 1'b0;
			core_abort <= 1'b0;
			// request stands while flag and enable are both set
			irq <= conversion_complete_flag & complete_interrupt_enable;
			// reading the low result pops the result fifo and clears
			// the flag; a completion in the same cycle wins below
			if (rd_lo) begin
				conversion_complete_flag <= 1'b0;
				if (fifo_on) begin
					rptr <= rptr + 3'h1;
				end
			end
			if (cf_we) begin
				cfill <= cf_next;
			end
			// a new depth invalidates a partial fill, so start it over
			if (w_sc4) begin
				cfill <= 4'h0;
			end
			if (mode_wr || w_sc1 || stop_abort) begin
				// results already stored stay untouched on any abort
				core_abort <= (state == ST_CONV);
				cidx <= 4'h0;
				rcnt <= 4'h0;
				rptr <= 3'h0;
				any_t <= 1'b0;
				all_t <= 1'b1;
				if (w_sc1) begin
					conversion_complete_flag <= 1'b0;
				end
				// a channel write arms a new sequence once the fifo is ready, or outside
				// fifo mode for any channel but off; anything else lands in idle
				if (w_sc1 && !stop_abort && (fifo_on ? cf_ready_next
					: (hwdata[4:0] != `ACFS_CHAN_OFF))) begin
					state <= ST_ARM;
				end else begin
					state <= ST_IDLE;
				end
			end else begin
				// wait mode has no effect here: conversions run on
				case (state)
				ST_IDLE: begin
					// a new hardware trigger resumes a halted sequence
					if (hw_trig_sel && hw_trigger &&
						(fifo_on ? fifo_ready
						: (channel_select_field != `ACFS_CHAN_OFF))) begin
						core_start <= 1'b1;
						core_channel <= chan_now;
						state <= ST_CONV;
					end
				end
				ST_ARM: begin
					// software trigger goes at once, hardware waits
					if (!hw_trig_sel || hw_trigger) begin
						core_start <= 1'b1;
						core_channel <= chan_now;
						state <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (core_done && !fifo_on) begin
						// single channel: a false compare drops the result
						if (!cmp_en || cond) begin
							res_reg <= store_val;
							conversion_complete_flag <= 1'b1;
						end
						if (continuous_enable_bit) begin
							core_start <= 1'b1;
							core_channel <= channel_select_field;
						end else begin
							state <= ST_IDLE;
						end
					end else if (core_done) begin
						rcnt <= rcnt + 4'h1;
						any_t <= any_n;
						all_t <= all_n;
						if (last) begin
							// whole sequence done: flag from combined compare
							conversion_complete_flag <= !cmp_en ||
								(compare_combine_bit ? all_n : any_n);
							rcnt <= 4'h0;
							rptr <= 3'h0;
							cidx <= 4'h0;
							any_t <= 1'b0;
							all_t <= 1'b1;
							if (continuous_enable_bit) begin
								core_start <= 1'b1;
								core_channel <= chan_first;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							cidx <= cidx_nx;
							if (!hw_trig_sel) begin
								core_start <= 1'b1;
								core_channel <= chan_nx;
							end else begin
								state <= ST_ARM;
							end
						end
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule // acfs_top

// file: tb/acfs_core_model.sv
/* behavioural model of the analog core behind the converter control.
   assumes start, abort and channel arrive on hclk from the block. */
`timescale 1ns/10ps
module acfs_core_model (
	input  wire       hclk,
	input  wire       hresetn,
	input  wire       core_start,
	input  wire       core_abort,
	input  wire [4:0] core_channel,
	input  wire       slow,
	input  wire [9:0] base,
	output reg        core_done,
	output reg  [9:0] core_result
);
	reg       busy; // a conversion is running
	reg [3:0] cnt;  // cycles left
	reg [4:0] chan; // channel latched at start
	// result toggles outside done so a stale value never matches
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy        <= 1'b0;
			cnt         <= 4'h0;
			chan        <= 5'h00;
			core_done   <= 1'b0;
			core_result <= 10'h000;
		end else begin
			core_done   <= 1'b0;
			core_result <= ~core_result;
			if (core_abort) begin
				busy <= 1'b0;
			end else if (core_start) begin
				busy <= 1'b1;
				cnt  <= slow ? 4'hA : 4'h1;
				chan <= core_channel;
			end else if (busy && cnt == 4'h0) begin
				busy        <= 1'b0;
				core_done   <= 1'b1;
				core_result <= {chan, 5'h00} ^ base;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule // acfs_core_model

// file: tb/acfs_asserts.sv
/* port checker of the converter control.
   assumes hready is tied to hreadyout. */
`timescale 1ns/10ps
module acfs_asserts (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire        hready,
	input wire        hreadyout,
	input wire [31:0] hrdata,
	input wire        hresp,
	input wire        core_done,
	input wire        core_start,
	input wire        core_abort,
	input wire [4:0]  core_channel,
	input wire        irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// a transfer taken by the slave
	wire acc = hsel & htrans[1] & hready;
	chk_irq_after_done: assert property (
		$rose(irq) |-> $past(core_done, 2)) else $error("irq without done");
	chk_irq_drop_cause: assert property (
		$fell(irq) |-> $past(acc, 2) || $past(acc, 3))
		else $error("irq fell without access");
	chk_start_pulse: assert property (
		core_start |=> !core_start) else $error("start not a pulse");
	chk_start_abort: assert property (
		core_start |-> !core_abort) else $error("start with abort");
	chk_chan_at_start: assert property (
		$changed(core_channel) |-> core_start)
		else $error("channel moved without start");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_ready_high: assert property (hreadyout == 1'b1)
		else $error("wait state inserted");
	chk_rdata_idle: assert property (
		!(acc && !hwrite && hsize == 3'h2) |=> hrdata == 32'h00000000)
		else $error("read data outside data phase");
endmodule // acfs_asserts

// file: tb/acfs_test.sv
/* self-checking bench of the converter control: random compares,
   fifo sequences under both triggers, stop abort.
   assumes the core model answers each start unless aborted. */
`timescale 1ns/10ps
`include "acfs_defs.vh"
module acfs_test;
	reg         hclk, hresetn, hsel, hwrite, hw_trigger, stop_mode;
	reg         slow, dir, flag;
	reg  [31:0] haddr, hwdata, q, rnd;
	reg  [1:0]  htrans;
	reg  [2:0]  hsize;
	reg  [9:0]  base, cv, r, ex;
	reg  [4:0]  ch;
	wire        hreadyout, hresp, core_done, core_start, core_abort, irq;
	wire [31:0] hrdata;
	wire [9:0]  core_result;
	wire [4:0]  core_channel;
	integer     seed, error_cnt, check_count, i, ns, nd;
	integer     n_start = 0;
	integer     n_done = 0;
	acfs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .hw_trigger(hw_trigger),
		.stop_mode(stop_mode), .core_done(core_done),
		.core_result(core_result), .core_start(core_start),
		.core_abort(core_abort), .core_channel(core_channel), .irq(irq));
	acfs_core_model i_core (.hclk(hclk), .hresetn(hresetn),
		.core_start(core_start), .core_abort(core_abort),
		.core_channel(core_channel), .slow(slow), .base(base),
		.core_done(core_done), .core_result(core_result));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// count core starts and dones; non-blocking so that a task polling
	// at the same edge always sees the count from before that edge
	always @(posedge hclk) begin
		if (core_start === 1'b1) n_start <= n_start + 1;
		if (core_done === 1'b1) n_done <= n_done + 1;
	end
	function [9:0] res_of(input [4:0] c);
		res_of = {c, 5'h00} ^ base;
	endfunction
	task give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input [8*8:1] nm, input [31:0] got, input [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("wrong value %0s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one edge with hready high, bounded
	task hold;
		integer k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k < 50) begin
			@(posedge hclk);
			k = k + 1;
		end
		if (k == 50) begin
			error_cnt = error_cnt + 1;
			give_verdict;
		end
	endtask
	// single word transfer, read data left in q
	task bus(input [7:0] a, input w, input [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		hold;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hold;
		q = hrdata;
	endtask
	task wait_done(input integer t);
		integer k;
		k = 0;
		while (n_done < t && k < 300) begin
			@(posedge hclk);
			k = k + 1;
		end
		if (k == 300) begin
			error_cnt = error_cnt + 1;
			give_verdict;
		end
	endtask
	initial begin
		seed = 33; error_cnt = 0; check_count = 0;
		hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
		hwrite = 1'b0; hsize = 3'h0; hwdata = 32'h0; hw_trigger = 1'b0;
		stop_mode = 1'b0; slow = 1'b0; base = 10'h2A5; ex = 10'h000;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(8'h40, 1'b0, 32'h0);
		chk("unmapped", q, 32'h0);
		// single conversions: compare off, then both directions
		for (i = 0; i < 8; i = i + 1) begin
			rnd = $random(seed);
			base = rnd[9:0];
			rnd = $random(seed);
			ch = rnd[4:0] & 5'h1E;
			r = res_of(ch);
			rnd = $random(seed);
			cv = (i == 3) ? r : rnd[9:0];
			dir = i[0];
			slow <= i[1];
			flag = (i == 0) || (dir ? r >= cv : r < cv);
			if (flag) ex = (i == 0) ? r : r - cv;
			bus(`ACFS_SC2_OFF, 1'b1, {29'h0, dir, i != 0, 1'b0});
			bus(`ACFS_CVH_OFF, 1'b1, {30'h0, cv[9:8]});
			bus(`ACFS_CVL_OFF, 1'b1, {24'h0, cv[7:0]});
			bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h2, ch});
			wait_done(n_done + 1);
			repeat (3) @(posedge hclk);
			chk("irq", irq, flag);
			bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
			chk("flag", q[7], flag);
			bus(`ACFS_RH_OFF, 1'b0, 32'h0);
			chk("res_hi", q, ex[9:8]);
			bus(`ACFS_RL_OFF, 1'b0, 32'h0);
			chk("res_lo", q, ex[7:0]);
		end
		// three level fifo, software trigger, slow core
		slow <= 1'b1;
		bus(`ACFS_SC2_OFF, 1'b1, 32'h0);
		bus(`ACFS_SC4_OFF, 1'b1, 32'h2);
		ns = n_start;
		nd = n_done;
		for (i = 0; i < 3; i = i + 1) begin
			bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h2, i[4:0] * 5'h5 + 5'h1});
			repeat (4) @(posedge hclk);
			if (i < 2) chk("early", n_start, ns);
		end
		wait_done(nd + 1);
		bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
		chk("active", q[4:0], 5'h6);
		chk("midflag", q[7], 1'b0);
		wait_done(nd + 3);
		repeat (3) @(posedge hclk);
		chk("starts", n_start, ns + 3);
		bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
		chk("seqflag", q[7], 1'b1);
		for (i = 0; i < 3; i = i + 1) begin
			r = res_of(i[4:0] * 5'h5 + 5'h1);
			bus(`ACFS_RH_OFF, 1'b0, 32'h0);
			chk("fifo_hi", q, r[9:8]);
			bus(`ACFS_RL_OFF, 1'b0, 32'h0);
			chk("fifo_lo", q, r[7:0]);
		end
		// hardware trigger: one conversion per trigger
		bus(`ACFS_SC2_OFF, 1'b1, 32'h1);
		ns = n_start;
		nd = n_done;
		for (i = 0; i < 3; i = i + 1)
			bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h2, 5'h9});
		repeat (8) @(posedge hclk);
		chk("no_trig", n_start, ns);
		for (i = 0; i < 3; i = i + 1) begin
			hw_trigger <= 1'b1;
			@(posedge hclk);
			hw_trigger <= 1'b0;
			wait_done(nd + i + 1);
			repeat (6) @(posedge hclk);
			chk("per_trig", n_start, ns + i + 1);
		end
		bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
		chk("hw_flag", q[7], 1'b1);
		// stop on the bus clock kills the running conversion
		bus(`ACFS_SC2_OFF, 1'b1, 32'h0);
		bus(`ACFS_SC4_OFF, 1'b1, 32'h0);
		bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h0, 5'h3});
		repeat (3) @(posedge hclk);
		nd = n_done;
		ns = n_start;
		stop_mode <= 1'b1;
		repeat (20) @(posedge hclk);
		stop_mode <= 1'b0;
		chk("stop", n_done, nd);
		repeat (4) @(posedge hclk);
		chk("resume", n_start, ns);
		bus(`ACFS_RH_OFF, 1'b0, 32'h0);
		chk("keep_hi", q, ex[9:8]);
		bus(`ACFS_RL_OFF, 1'b0, 32'h0);
		chk("keep_lo", q, ex[7:0]);
		// two level fifo compare: one limit met, then any versus all
		for (i = 0; i < 2; i = i + 1) begin
			nd = n_done;
			r = res_of(5'h2);
			ex = res_of(5'h7);
			cv = (r > ex) ? r : ex;
			bus(`ACFS_SC4_OFF, 1'b1, {25'h0, 1'b0, i[0], 2'h0, 3'h1});
			bus(`ACFS_SC2_OFF, 1'b1, 32'h6);
			bus(`ACFS_CVH_OFF, 1'b1, {30'h0, cv[9:8]});
			bus(`ACFS_CVL_OFF, 1'b1, {24'h0, cv[7:0]});
			bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h0, 5'h2});
			bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h0, 5'h7});
			wait_done(nd + 2);
			repeat (3) @(posedge hclk);
			bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
			chk("cmb_flag", q[7], !i[0]);
			r = r - cv;
			ex = ex - cv;
			bus(`ACFS_RH_OFF, 1'b0, 32'h0);
			chk("cmp_hi", q, r[9:8]);
			bus(`ACFS_RL_OFF, 1'b0, 32'h0);
			chk("cmp_lo", q, r[7:0]);
			bus(`ACFS_RH_OFF, 1'b0, 32'h0);
			chk("cmp_hi", q, ex[9:8]);
			bus(`ACFS_RL_OFF, 1'b0, 32'h0);
			chk("cmp_lo", q, ex[7:0]);
		end
		// scan: the first channel repeats until the result fifo is full
		bus(`ACFS_SC2_OFF, 1'b1, 32'h0);
		bus(`ACFS_SC4_OFF, 1'b1, 32'h42);
		nd = n_done;
		ns = n_start;
		bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h0, 5'h4});
		wait_done(nd + 3);
		repeat (3) @(posedge hclk);
		chk("scan_st", n_start, ns + 3);
		bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
		chk("scan_fl", q[7], 1'b1);
		chk("scan_ch", q[4:0], 5'h4);
		r = res_of(5'h4);
		for (i = 0; i < 3; i = i + 1) begin
			bus(`ACFS_RH_OFF, 1'b0, 32'h0);
			chk("scan_hi", q, r[9:8]);
			bus(`ACFS_RL_OFF, 1'b0, 32'h0);
			chk("scan_lo", q, r[7:0]);
		end
		// continuous fifo: the sequence restarts from the first entry
		bus(`ACFS_SC4_OFF, 1'b1, 32'h1);
		nd = n_done;
		ns = n_start;
		bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h1, 5'h1});
		bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h1, 5'h5});
		wait_done(nd + 2);
		bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
		chk("cont_ch", q[4:0], 5'h1);
		chk("cont_fl", q[7], 1'b1);
		chk("cont_st", n_start, ns + 3);
		// a mode write ends the running loop with no further result
		bus(`ACFS_SC2_OFF, 1'b1, 32'h0);
		nd = n_done;
		repeat (20) @(posedge hclk);
		chk("mode_ab", n_done, nd);
		// async clock: stop lets a single conversion finish, fifo not
		bus(`ACFS_SC3_OFF, 1'b1, 32'h3);
		bus(`ACFS_SC4_OFF, 1'b1, 32'h0);
		nd = n_done;
		bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h0, 5'h3});
		stop_mode <= 1'b1;
		wait_done(nd + 1);
		repeat (3) @(posedge hclk);
		bus(`ACFS_SC1_OFF, 1'b0, 32'h0);
		chk("as_flag", q[7], 1'b1);
		bus(`ACFS_SC4_OFF, 1'b1, 32'h1);
		bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h0, 5'h3});
		bus(`ACFS_SC1_OFF, 1'b1, {24'h0, 3'h0, 5'h6});
		nd = n_done;
		repeat (20) @(posedge hclk);
		chk("as_fifo", n_done, nd);
		stop_mode <= 1'b0;
		give_verdict;
	end
endmodule // acfs_test
bind acfs_top acfs_asserts i_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .core_done(core_done), .core_start(core_start),
	.core_abort(core_abort), .core_channel(core_channel), .irq(irq));
